// ### hw/perd_pkg.sv
// Purpose: Shared constants, types and helpers for the endpoint reset request link.
// Assumes: One 50 MHz core clock on both ends.
// Notes: Code 63 releases all, 62..47 type A, 46..15 type B, 0..14 neutral.
package perd_pkg;

    localparam int CLK_MHZ = 50;
    localparam int CODE_HOLD_TIME_US = 10;
    localparam int CODE_HOLD_CYCLES = CODE_HOLD_TIME_US * CLK_MHZ;
    localparam int COLD_RESET_HOLD_TIME_US = 10;
    localparam int COLD_HOLD_CYCLES = COLD_RESET_HOLD_TIME_US * CLK_MHZ;
    localparam int HOLD_CNT_W = 10;

    localparam int CODE_W = 6;
    localparam int NUM_ENDPOINTS = 48;
    localparam int NUM_TYPEA = 16;
    localparam int NUM_TYPEB = 32;
    localparam int PORTS_PER_GROUP = 4;
    localparam int NUM_TYPEA_CX = NUM_TYPEA / PORTS_PER_GROUP;
    localparam int NUM_TYPEB_GRP = NUM_TYPEB / PORTS_PER_GROUP;
    localparam int INDEX_W = 6;

    localparam logic [CODE_W-1:0] CODE_NEUTRAL = 6'h00;
    localparam logic [CODE_W-1:0] CODE_NEUTRAL_MAX = 6'h0E;
    localparam logic [CODE_W-1:0] CODE_TYPEB_LAST = 6'h0F;
    localparam logic [CODE_W-1:0] CODE_TYPEB_FIRST = 6'h2E;
    localparam logic [CODE_W-1:0] CODE_TYPEA_LAST = 6'h2F;
    localparam logic [CODE_W-1:0] CODE_TYPEA_FIRST = 6'h3E;
    localparam logic [CODE_W-1:0] CODE_RELEASE_ALL = 6'h3F;
    localparam logic [INDEX_W-1:0] LAST_ENDPOINT = 6'h2F;

    localparam logic [1:0] PORT_0 = 2'h0;
    localparam logic [1:0] PORT_2 = 2'h2;

    // Lane split of one 16-lane complex (type A) or one 8-lane group (type B)
    typedef enum logic [1:0] {
        WIDTH_QUAD = 2'b00,
        WIDTH_SPLIT = 2'b01,
        WIDTH_SINGLE = 2'b10
    } perd_width_t;

    typedef enum logic [1:0] {
        CMD_RESET_ONE = 2'b00,
        CMD_RESET_ALL = 2'b01,
        CMD_RELEASE_ALL = 2'b10
    } perd_cmd_t;

    // Endpoint 0..15 are type A, 16..47 type B; both map to 62 - index
    function automatic logic [CODE_W-1:0] code_for_index(input logic [INDEX_W-1:0] idx);
        code_for_index = CODE_W'(CODE_TYPEA_FIRST - idx);
    endfunction : code_for_index

    // Whether a port line carries a link for the given split
    function automatic logic port_used(input perd_width_t width, input logic [1:0] port);
        unique case (width)
            WIDTH_SINGLE: port_used = (port == PORT_0);
            WIDTH_SPLIT: port_used = (port == PORT_0) || (port == PORT_2);
            default: port_used = 1'b1;
        endcase
    endfunction : port_used

endpackage : perd_pkg

// ### hw/perd_link_if.sv
// Purpose: Board-level pins between the requesting processor and the reset decoder.
// Assumes: All signals are plain single-driver wires.
// Notes: The decoder end makes the cold reset and the timer clock and reset.
interface perd_link_if;
    import perd_pkg::*;

    logic [CODE_W-1:0] request_code;
    logic chip_cold_reset_n;
    logic timer_reference_clock;
    logic timer_counter_reset_n;

    modport requester (
        output request_code,
        input chip_cold_reset_n,
        input timer_reference_clock,
        input timer_counter_reset_n
    );

    modport decoder (
        input request_code,
        output chip_cold_reset_n,
        output timer_reference_clock,
        output timer_counter_reset_n
    );

endinterface : perd_link_if

// ### hw/perd_requester.sv
// Purpose: Processor end: turns reset commands into held request codes, keeps the timer.
// Assumes: Link pins come from another party and are synchronised.
// Notes: A reset-all walks all endpoint codes one after another.
module perd_requester
    import perd_pkg::*;
#(
    parameter int NUM_SERDES = 8,
    parameter int COUNT_W = 64
) (
    input logic core_clk_i,
    input logic reset_n_i,
    perd_link_if.requester link,
    input logic cmd_valid_i,
    input perd_cmd_t cmd_i,
    input logic [INDEX_W-1:0] cmd_index_i,
    output logic cmd_ready_o,
    input logic [NUM_SERDES-1:0] refclk_select_i,
    output logic [NUM_SERDES-1:0] refclk_select_o,
    output logic [COUNT_W-1:0] global_count_o
);

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } perd_req_state_t;

    typedef struct packed {
        perd_req_state_t state;
        logic [CODE_W-1:0] code;
        logic [HOLD_CNT_W-1:0] hold_cnt;
        logic walking;
        logic [INDEX_W-1:0] walk_idx;
        logic ready;
        logic crst_s1;
        logic crst_s2;
        logic tclk_s1;
        logic tclk_s2;
        logic tclk_s3;
        logic trst_s1;
        logic trst_s2;
        logic [COUNT_W-1:0] count;
        logic [NUM_SERDES-1:0] refsel;
    } perd_req_regs_t;

    perd_req_regs_t state_ff;
    perd_req_regs_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.crst_s1 = link.chip_cold_reset_n;
        nxt_state.crst_s2 = state_ff.crst_s1;
        nxt_state.tclk_s1 = link.timer_reference_clock;
        nxt_state.tclk_s2 = state_ff.tclk_s1;
        nxt_state.tclk_s3 = state_ff.tclk_s2;
        nxt_state.trst_s1 = link.timer_counter_reset_n;
        nxt_state.trst_s2 = state_ff.trst_s1;
        nxt_state.refsel = refclk_select_i;
        if (!state_ff.trst_s2) begin
            nxt_state.count = '0;
        end else if (state_ff.tclk_s2 && !state_ff.tclk_s3) begin
            nxt_state.count = state_ff.count + COUNT_W'(1);
        end
        if (!state_ff.crst_s2) begin
            nxt_state.state = ST_IDLE;
            nxt_state.code = CODE_NEUTRAL;
            nxt_state.walking = 1'b0;
            nxt_state.ready = 1'b0;
        end else begin
            unique case (state_ff.state)
                ST_IDLE: begin
                    nxt_state.ready = 1'b1;
                    if (cmd_valid_i && state_ff.ready) begin
                        nxt_state.hold_cnt = '0;
                        unique case (cmd_i)
                            CMD_RESET_ONE: begin
                                if (cmd_index_i <= LAST_ENDPOINT) begin
                                    nxt_state.code = code_for_index(cmd_index_i);
                                    nxt_state.state = ST_HOLD;
                                    nxt_state.ready = 1'b0;
                                end
                            end
                            CMD_RESET_ALL: begin
                                nxt_state.walk_idx = '0;
                                nxt_state.walking = 1'b1;
                                nxt_state.code = code_for_index('0);
                                nxt_state.state = ST_HOLD;
                                nxt_state.ready = 1'b0;
                            end
                            CMD_RELEASE_ALL: begin
                                nxt_state.code = CODE_RELEASE_ALL;
                                nxt_state.state = ST_HOLD;
                                nxt_state.ready = 1'b0;
                            end
                            default: begin
                                nxt_state.ready = 1'b1;
                            end
                        endcase
                    end
                end
                ST_HOLD: begin
                    if (state_ff.hold_cnt != HOLD_CNT_W'(CODE_HOLD_CYCLES - 1)) begin
                        nxt_state.hold_cnt = state_ff.hold_cnt + HOLD_CNT_W'(1);
                    end else if (state_ff.walking && state_ff.walk_idx != LAST_ENDPOINT) begin
                        nxt_state.walk_idx = state_ff.walk_idx + INDEX_W'(1);
                        nxt_state.code = code_for_index(nxt_state.walk_idx);
                        nxt_state.hold_cnt = '0;
                    end else begin
                        nxt_state.walking = 1'b0;
                        nxt_state.state = ST_IDLE;
                        nxt_state.ready = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign link.request_code = state_ff.code;
    assign cmd_ready_o = state_ff.ready;
    assign refclk_select_o = state_ff.refsel;
    assign global_count_o = state_ff.count;

endmodule : perd_requester

// ### hw/perd_decoder.sv
// Purpose: Board decoder end: captures stable request codes and drives endpoint resets.
// Assumes: Request code pins are asynchronous and pass a two-stage synchroniser.
// Notes: Also makes the cold reset, the 25 MHz timer clock and the timer reset.
module perd_decoder
    import perd_pkg::*;
(
    input logic core_clk_i,
    input logic reset_n_i,
    perd_link_if.decoder link,
    input logic power_good_i,
    input perd_width_t typea_width_i [NUM_TYPEA_CX],
    input perd_width_t typeb_width_i [NUM_TYPEB_GRP],
    output logic [NUM_TYPEA-1:0] typea_endpoint_reset_n_o,
    output logic [NUM_TYPEB-1:0] typeb_endpoint_reset_n_o,
    output logic [CODE_W-1:0] applied_code_o
);

    typedef struct packed {
        logic [CODE_W-1:0] code_s1;
        logic [CODE_W-1:0] code_s2;
        logic [CODE_W-1:0] last_code;
        logic [HOLD_CNT_W-1:0] stable_cnt;
        logic applied;
        logic [CODE_W-1:0] applied_code;
        logic pg_s1;
        logic pg_s2;
        logic [HOLD_CNT_W-1:0] cold_cnt;
        logic cold_rst_n;
        logic tclk;
        logic tmr_rst_n;
        logic [NUM_TYPEA-1:0] typea;
        logic [NUM_TYPEB-1:0] typeb;
    } perd_dec_regs_t;

    perd_dec_regs_t state_ff;
    perd_dec_regs_t nxt_state;

    // Lines whose port carries a link under the present split
    logic [NUM_TYPEA-1:0] typea_used;
    logic [NUM_TYPEB-1:0] typeb_used;

    // Kind of action a settled code asks for
    typedef enum logic [1:0] {
        KIND_NEUTRAL = 2'b00,
        KIND_TYPEA = 2'b01,
        KIND_TYPEB = 2'b10,
        KIND_RELEASE = 2'b11
    } perd_code_kind_t;

    // The bands are contiguous, so testing from the top picks the band
    function automatic perd_code_kind_t code_kind(input logic [CODE_W-1:0] code);
        if (code == CODE_RELEASE_ALL) begin
            code_kind = KIND_RELEASE;
        end else if (code >= CODE_TYPEA_LAST) begin
            code_kind = KIND_TYPEA;
        end else if (code >= CODE_TYPEB_LAST) begin
            code_kind = KIND_TYPEB;
        end else begin
            code_kind = KIND_NEUTRAL;
        end
    endfunction : code_kind

    // Line position in a band, counted down from the band's first code
    function automatic logic [CODE_W-1:0] band_pos(input logic [CODE_W-1:0] first,
        input logic [CODE_W-1:0] code);
        band_pos = CODE_W'(first - code);
    endfunction : band_pos

    // Split group that owns a line
    function automatic int group_of(input int pos);
        group_of = pos / PORTS_PER_GROUP;
    endfunction : group_of

    // Port of a line within its split group
    function automatic logic [1:0] port_of(input int pos);
        port_of = 2'(pos % PORTS_PER_GROUP);
    endfunction : port_of

    // Window counters step by one; callers stop them at the window's end
    function automatic logic [HOLD_CNT_W-1:0] count_up(input logic [HOLD_CNT_W-1:0] cnt);
        count_up = cnt + HOLD_CNT_W'(1);
    endfunction : count_up

    // Last count of a window lasting the given number of cycles
    function automatic logic window_end(input logic [HOLD_CNT_W-1:0] cnt, input int cycles);
        window_end = (cnt == HOLD_CNT_W'(cycles - 1));
    endfunction : window_end

    always_comb begin
        typea_used = '0;
        typeb_used = '0;
        for (int i = 0; i < NUM_TYPEA; i++) begin
            typea_used[i] = port_used(typea_width_i[group_of(i)], port_of(i));
        end
        for (int j = 0; j < NUM_TYPEB; j++) begin
            typeb_used[j] = port_used(typeb_width_i[group_of(j)], port_of(j));
        end
    end

    always_comb begin
        logic [CODE_W-1:0] idx;
        idx = '0;
        nxt_state = state_ff;

        // Request code pins are foreign to this clock
        nxt_state.code_s1 = link.request_code;
        nxt_state.code_s2 = state_ff.code_s1;
        nxt_state.pg_s1 = power_good_i;
        nxt_state.pg_s2 = state_ff.pg_s1;

        // Cold reset released only after power has stood for the full window
        if (!state_ff.pg_s2) begin
            nxt_state.cold_cnt = '0;
            nxt_state.cold_rst_n = 1'b0;
        end else if (!window_end(state_ff.cold_cnt, COLD_HOLD_CYCLES)) begin
            nxt_state.cold_cnt = count_up(state_ff.cold_cnt);
        end else begin
            nxt_state.cold_rst_n = 1'b1;
        end

        // Timer clock is the core clock halved
        nxt_state.tclk = ~state_ff.tclk;
        if (!state_ff.cold_rst_n) begin
            nxt_state.tmr_rst_n = 1'b0;
        end else if (!state_ff.tclk) begin
            nxt_state.tmr_rst_n = 1'b1;
        end

        // Stability window: any change restarts it
        if (state_ff.code_s2 != state_ff.last_code) begin
            nxt_state.last_code = state_ff.code_s2;
            // First synced sighting already counts as one cycle of the window
            nxt_state.stable_cnt = HOLD_CNT_W'(1);
            nxt_state.applied = 1'b0;
        end else if (!window_end(state_ff.stable_cnt, CODE_HOLD_CYCLES)) begin
            nxt_state.stable_cnt = count_up(state_ff.stable_cnt);
        end else if (!state_ff.applied) begin
            nxt_state.applied = 1'b1;
            nxt_state.applied_code = state_ff.last_code;
            // Each settled code acts once
            unique case (code_kind(state_ff.last_code))
                KIND_RELEASE: begin
                    nxt_state.typea = typea_used;
                    nxt_state.typeb = typeb_used;
                end
                KIND_TYPEA: begin
                    idx = band_pos(CODE_TYPEA_FIRST, state_ff.last_code);
                    nxt_state.typea[idx[3:0]] = 1'b0;
                end
                KIND_TYPEB: begin
                    idx = band_pos(CODE_TYPEB_FIRST, state_ff.last_code);
                    nxt_state.typeb[idx[4:0]] = 1'b0;
                end
                KIND_NEUTRAL: begin
                    nxt_state.applied_code = CODE_NEUTRAL;
                end
            endcase
        end

        // Unlinked ports never leave reset
        nxt_state.typea = nxt_state.typea & typea_used;
        nxt_state.typeb = nxt_state.typeb & typeb_used;

        // Cold reset overrides every code
        if (!state_ff.cold_rst_n) begin
            nxt_state.typea = '0;
            nxt_state.typeb = '0;
            nxt_state.stable_cnt = '0;
            nxt_state.applied = 1'b0;
            nxt_state.applied_code = CODE_NEUTRAL;
        end
    end

    // Power-up leaves every endpoint in reset
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign link.chip_cold_reset_n = state_ff.cold_rst_n;
    assign link.timer_reference_clock = state_ff.tclk;
    assign link.timer_counter_reset_n = state_ff.tmr_rst_n;
    assign typea_endpoint_reset_n_o = state_ff.typea;
    assign typeb_endpoint_reset_n_o = state_ff.typeb;
    assign applied_code_o = state_ff.applied_code;

endmodule : perd_decoder

// ### test/perd_link_chk.sv
// Purpose: Assertions on the pins between the requester and the reset decoder.
// Assumes: One core clock; reset_n_i is active low.
// Notes: Hold figures come from the shared package.
module perd_link_chk
    import perd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [CODE_W-1:0] request_code,
    input wire logic chip_cold_reset_n,
    input wire logic timer_reference_clock,
    input wire logic timer_counter_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [CODE_W-1:0] code_ff;
    logic [HOLD_CNT_W-1:0] hold_cnt_ff;
    logic [HOLD_CNT_W-1:0] cold_cnt_ff;

    // Saturating counts of how long the code and the cold reset have stood
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code_ff <= '0;
            hold_cnt_ff <= '0;
            cold_cnt_ff <= '0;
        end else begin
            code_ff <= request_code;
            if (request_code != code_ff) begin
                hold_cnt_ff <= '0;
            end else if (hold_cnt_ff != '1) begin
                hold_cnt_ff <= hold_cnt_ff + 1'b1;
            end
            if (chip_cold_reset_n) begin
                cold_cnt_ff <= '0;
            end else if (cold_cnt_ff != '1) begin
                cold_cnt_ff <= cold_cnt_ff + 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_code_hold;
        (request_code != code_ff) && chip_cold_reset_n |-> hold_cnt_ff >= CODE_HOLD_CYCLES - 1;
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code changed too early");

    property p_code_range;
        request_code == CODE_NEUTRAL || request_code >= CODE_TYPEB_LAST;
    endproperty
    a_code_range: assert property (p_code_range) else $error("neutral code issued");

    property p_code_cold;
        !chip_cold_reset_n [*6] |-> request_code == CODE_NEUTRAL;
    endproperty
    a_code_cold: assert property (p_code_cold) else $error("code not idle in cold reset");

    property p_cold_hold;
        $rose(chip_cold_reset_n) |-> cold_cnt_ff >= COLD_HOLD_CYCLES;
    endproperty
    a_cold_hold: assert property (p_cold_hold) else $error("cold reset low too short");

    property p_timer_clk;
        timer_reference_clock |=> !timer_reference_clock ##1 timer_reference_clock;
    endproperty
    a_timer_clk: assert property (p_timer_clk) else $error("timer clock not half rate");

    property p_timer_rise;
        $rose(timer_counter_reset_n) |-> $rose(timer_reference_clock) && chip_cold_reset_n;
    endproperty
    a_timer_rise: assert property (p_timer_rise) else $error("timer reset rise unaligned");

    property p_timer_after_cold;
        $rose(chip_cold_reset_n) |-> ##[0:3] timer_counter_reset_n;
    endproperty
    a_timer_after_cold: assert property (p_timer_after_cold) else $error("timer reset late");

    property p_timer_drop;
        $fell(chip_cold_reset_n) |-> ##[0:2] !timer_counter_reset_n;
    endproperty
    a_timer_drop: assert property (p_timer_drop) else $error("timer reset not dropped");

endmodule : perd_link_chk

// ### test/pcie_endpoint_reset_decoder_tb.sv
// Purpose: Self-checking bench joining the requester and the reset decoder.
// Assumes: Both ends share one 50 MHz clock; both decoders share one power-good input.
// Notes: A second decoder on its own link takes hand-made codes.
module pcie_endpoint_reset_decoder_tb import perd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {perd_cmd_t cmd; logic [5:0] idx; logic [5:0] code;} perd_row_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic power_good = 1'b1;
    logic cmd_valid = 1'b0;
    perd_cmd_t cmd = CMD_RESET_ONE;
    logic [5:0] cmd_index = 6'h00;
    logic cmd_ready;
    logic [7:0] sel_in = 8'hA5;
    logic [7:0] sel_out;
    logic [63:0] count;
    logic [63:0] g0;
    logic [15:0] ea;
    logic [15:0] ea2;
    logic [31:0] eb;
    logic [31:0] eb2;
    logic [5:0] applied;
    logic [47:0] um;
    logic [47:0] exp_ln;
    logic [47:0] exp2;
    int err_total = 0;
    int tests_run = 0;
    perd_width_t wa [NUM_TYPEA_CX] = '{WIDTH_QUAD, WIDTH_SINGLE, WIDTH_SPLIT, WIDTH_QUAD};
    perd_width_t wb [NUM_TYPEB_GRP] = '{WIDTH_QUAD, WIDTH_QUAD, WIDTH_QUAD, WIDTH_SINGLE,
        WIDTH_QUAD, WIDTH_SPLIT, WIDTH_QUAD, WIDTH_QUAD};
    perd_row_t rows [10] = '{
        '{CMD_RELEASE_ALL, 6'h00, 6'h3F}, '{CMD_RESET_ONE, 6'h00, 6'h3E},
        '{CMD_RESET_ONE, 6'h0F, 6'h2F}, '{CMD_RESET_ONE, 6'h10, 6'h2E},
        '{CMD_RESET_ONE, 6'h2F, 6'h0F}, '{CMD_RESET_ONE, 6'h05, 6'h39},
        '{CMD_RESET_ONE, 6'h0A, 6'h34}, '{CMD_RESET_ONE, 6'h30, 6'h34},
        '{CMD_RELEASE_ALL, 6'h00, 6'h3F}, '{CMD_RESET_ALL, 6'h00, 6'h0F}};

    always #10 core_clk = ~core_clk;

    perd_link_if link ();
    perd_link_if link2 ();
    perd_requester u_perd_requester (.core_clk_i(core_clk), .reset_n_i(reset_n), .link(link),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_index_i(cmd_index), .cmd_ready_o(cmd_ready),
        .refclk_select_i(sel_in), .refclk_select_o(sel_out), .global_count_o(count));
    perd_decoder u_perd_decoder (.core_clk_i(core_clk), .reset_n_i(reset_n), .link(link),
        .power_good_i(power_good), .typea_width_i(wa), .typeb_width_i(wb),
        .typea_endpoint_reset_n_o(ea), .typeb_endpoint_reset_n_o(eb), .applied_code_o(applied));
    // Second decoder whose link the bench drives in the requester's place
    perd_decoder u_perd_decoder_2 (.core_clk_i(core_clk), .reset_n_i(reset_n), .link(link2),
        .power_good_i(power_good), .typea_width_i(wa), .typeb_width_i(wb),
        .typea_endpoint_reset_n_o(ea2), .typeb_endpoint_reset_n_o(eb2), .applied_code_o());
    perd_link_chk u_perd_link_chk (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .request_code(link.request_code), .chip_cold_reset_n(link.chip_cold_reset_n),
        .timer_reference_clock(link.timer_reference_clock),
        .timer_counter_reset_n(link.timer_counter_reset_n));

    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : chk

    task automatic conclude();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    function automatic logic used(input perd_width_t w, input int p);
        return w == WIDTH_SINGLE ? p == 0 : (w == WIDTH_SPLIT ? p % 2 == 0 : 1'b1);
    endfunction : used

    task automatic wait_ready();
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 30000) begin
            @(negedge core_clk);
            k++;
        end
        chk("ready", 48'(cmd_ready), 48'h1);
    endtask : wait_ready

    task automatic run_row(input perd_row_t r);
        wait_ready();
        cmd_valid = 1'b1;
        cmd = r.cmd;
        cmd_index = r.idx;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        chk("code", 48'(link.request_code), 48'(r.cmd == CMD_RESET_ALL ? 6'h3E : r.code));
        chk("busy", 48'(cmd_ready), 48'(r.idx > LAST_ENDPOINT));
        if (r.cmd == CMD_RELEASE_ALL) begin
            exp_ln = um;
        end else if (r.cmd == CMD_RESET_ALL) begin
            exp_ln = '0;
        end else if (r.idx <= LAST_ENDPOINT) begin
            exp_ln[r.idx] = 1'b0;
        end
        wait_ready();
        repeat (8) @(negedge core_clk);
        chk("lines", {eb, ea}, exp_ln & um);
        chk("applied", 48'(applied), 48'(r.code));
    endtask : run_row

    task automatic drv(input logic [5:0] c, input int n);
        link2.request_code = c;
        repeat (n) @(negedge core_clk);
    endtask : drv

    initial begin
        link2.request_code = 6'h00;
        exp_ln = '0;
        for (int i = 0; i < 48; i++) begin
            um[i] = i < 16 ? used(wa[i / 4], i % 4) : used(wb[(i - 16) / 4], i % 4);
        end
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        chk("power-up lines", {eb, ea}, 48'h0);
        for (int i = 0; i < 10; i++) begin
            run_row(rows[i]);
        end
        sel_in = 8'h5A;
        @(negedge core_clk);
        chk("refclk", 48'(sel_out), 48'h5A);
        g0 = count;
        repeat (100) @(negedge core_clk);
        chk("timer count", 48'(count - g0), 48'h32);
        drv(CODE_RELEASE_ALL, 520);
        exp2 = um;
        chk("link2 release", {eb2, ea2}, exp2);
        drv(CODE_TYPEA_FIRST, 300);
        drv(6'h3D, 520);
        exp2[1] = 1'b0;
        chk("link2 short", {eb2, ea2}, exp2);
        for (int c = 0; c <= 14; c++) begin
            drv(6'(c), 520);
            chk("link2 neutral", {eb2, ea2}, exp2);
        end
        power_good = 1'b0;
        repeat (12) @(negedge core_clk);
        chk("cold lines", {eb, ea}, 48'h0);
        chk("cold lines2", {eb2, ea2}, 48'h0);
        power_good = 1'b1;
        wait_ready();
        chk("lines after cold", {eb, ea}, 48'h0);
        run_row(rows[0]);
        conclude();
    end

    initial begin
        repeat (90000) @(posedge core_clk);
        err_total++;
        conclude();
    end

endmodule : pcie_endpoint_reset_decoder_tb
